/* File: inc/wdt_params.svh */
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// Register byte offsets on the register bus
`define WDT_OFS_CAUSE        4'h0
`define WDT_OFS_CTRL         4'h4

// Reset-cause register fields
`define WDT_CAUSE_POWERON    0
`define WDT_CAUSE_PIN        1
`define WDT_CAUSE_BROWNOUT   2
`define WDT_CAUSE_TIMEOUT    3
`define WDT_CAUSE_SCAN       4
`define WDT_CAUSE_USB        5
`define WDT_CAUSE_RSV_MASK   8'hc0
`define WDT_CAUSE_RST_VAL    6'h01

// Control register fields
`define WDT_CTRL_PSEL0       0
`define WDT_CTRL_PSEL2       2
`define WDT_CTRL_RESET_EN    3
`define WDT_CTRL_UNLOCK      4
`define WDT_CTRL_PSEL3       5
`define WDT_CTRL_IRQ_EN      6
`define WDT_CTRL_IRQ_FLAG    7

// Prescaler code of the longest documented period
`define WDT_PSEL_MAX         4'h9

// System clock and watchdog oscillator rates in Hz
`define WDT_CLK_HZ           50000000
`define WDT_OSC_HZ           128000
// System clock cycles per oscillator cycle
`define WDT_OSC_DIV          (`WDT_CLK_HZ / `WDT_OSC_HZ)
// Oscillator cycles of the shortest time-out
`define WDT_BASE_CYCLES      2048
// System clock cycles the change window stays open
`define WDT_UNLOCK_CYCLES    4
`endif

/* File: inc/wdt_pkg.sv */
// Types shared by the watchdog and reset-cause logic
package wdt_pkg;

	// Watchdog operating mode, one-hot
	typedef enum logic [3:0] {
		MODE_STOPPED   = 4'b0001,
		MODE_IRQ       = 4'b0010,
		MODE_RESET     = 4'b0100,
		MODE_IRQ_RESET = 4'b1000
	} wdt_mode_type;

	// Reset events reported by the rest of the reset system
	typedef struct packed {
		logic usb;      // USB bus reset reset the core
		logic scan;     // Scan reset instruction reset the core
		logic brownout; // Brown-out reset
		logic pin;      // External pin reset
	} reset_event_type;

	// Avalon-MM slave request
	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} avs_req_type;

endpackage

/* File: hw/wdt_tick.sv */
// Divider making the watchdog oscillator rate as a one-cycle enable
`timescale 1ns/1ps
`default_nettype none

module wdt_tick #(
	parameter int DIV = 390
) (
	input  wire logic i_clk,  // System clock
	input  wire logic i_rst,  // Synchronous reset
	output logic      o_tick  // One-cycle pulse per oscillator cycle
);

	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

	logic [W-1:0] cnt_q; // Cycles within one oscillator period

	// Free-running count, wraps every DIV cycles
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= '0;
		end else if (cnt_q == W'(DIV - 1)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	// Pulse on the first cycle of each period, registered from the last count
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= (cnt_q == W'(DIV - 1));
		end
	end

endmodule
`default_nettype wire

/* File: hw/wdt_core.sv */
// Watchdog timer with reset-cause register behind an Avalon-MM slave
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "wdt_params.svh"
`default_nettype none

module wdt_core #(
	parameter int BASE_CYCLES = `WDT_BASE_CYCLES, // Shortest period
	parameter int OSC_DIV     = `WDT_OSC_DIV      // Clocks per osc cycle
) (
	input  wire logic                     i_clk,           // System clock
	input  wire logic                     i_rst,           // Power-on reset
	input  wire wdt_pkg::avs_req_type     i_avs,           // Bus request
	output logic [31:0]                   o_avs_readdata,  // Read data
	output logic                          o_avs_waitrequest, // Stall
	input  wire wdt_pkg::reset_event_type i_reset_event,   // Reset causes
	input  wire logic                     i_always_on_fuse, // Fuse level
	input  wire logic                     i_global_irq_en, // Global enable
	input  wire logic                     i_vector_ack,    // Vector entry
	input  wire logic                     i_restart,       // Restart insn
	output logic                          o_irq_req,       // Irq request
	output logic                          o_wdt_reset,     // Reset pulse
	output wdt_pkg::wdt_mode_type         o_mode           // Mode now
);

	import wdt_pkg::*;

	localparam int CW = 21; // Counter width, holds the longest period

	// Bus handshake state
	logic        ack_q;          // Second cycle of an access
	logic [31:0] rdata_q;        // Registered read data
	logic        wr_take;        // Write takes effect this edge
	logic        wr_cause;       // Write to the cause register
	logic        wr_ctrl;        // Write to the control register
	logic [7:0]  wbyte;          // Low write byte

	// Reset-cause flags, bits 5..0
	logic [5:0]  cause_q;
	logic [5:0]  cause_d;

	// Control register state
	logic        irq_flag_q;     // Timeout irq flag
	logic        irq_en_q;       // Timeout irq enable as stored
	logic        reset_en_q;     // Reset enable as stored
	logic [3:0]  psel_q;         // Period select code
	logic        unlock_q;       // Change window open
	logic [1:0]  unlock_cnt_q;   // Cycles the window has been open

	// Derived control
	logic        irq_en_eff;     // Irq enable after fuse lock
	logic        reset_en_eff;   // Reset enable after overrides
	wdt_mode_type mode;          // Decoded mode
	logic        sys_reset;      // Any reset that reinitialises control
	logic [7:0]  ctrl_rd;        // Control register read view

	// Counter
	logic        tick;           // Oscillator-rate enable
	logic [CW-1:0] cnt_q;        // Oscillator cycles since restart
	logic [CW-1:0] limit;        // Last count of the period
	logic        timeout;        // Period reached this cycle
	logic        to_set_flag;    // Timeout raises the irq flag
	logic        to_reset;       // Timeout asks for a reset

	// Oscillator-rate enable
	wdt_tick #(
		.DIV (OSC_DIV)
	) u_tick (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.o_tick (tick)
	);

	// Bus slave: every access takes two cycles, answer in the second
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (i_avs.read | i_avs.write) & ~ack_q;
		end
	end

	assign o_avs_waitrequest = (i_avs.read | i_avs.write) & ~ack_q;
	assign wr_take  = i_avs.write & ack_q & i_avs.byteenable[0];
	assign wr_cause = wr_take & (i_avs.address == `WDT_OFS_CAUSE);
	assign wr_ctrl  = wr_take & (i_avs.address == `WDT_OFS_CTRL);
	assign wbyte    = i_avs.writedata[7:0];

	// Read data captured in the first cycle; unmapped reads give zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_q <= 32'h0;
		end else if (i_avs.read & ~ack_q) begin
			if (i_avs.address == `WDT_OFS_CAUSE) begin
				rdata_q <= {24'h0, 2'b00, cause_q};
			end else if (i_avs.address == `WDT_OFS_CTRL) begin
				rdata_q <= {24'h0, ctrl_rd};
			end else begin
				rdata_q <= 32'h0;
			end
		end
	end

	assign o_avs_readdata = rdata_q;

	// Any system reset reinitialises the watchdog control
	assign sys_reset = (|i_reset_event) | o_wdt_reset;

	// Cause flags: hardware set wins over a software clear
	always_comb begin
		cause_d = cause_q;
		if (wr_cause) begin
			// Writing zero clears a flag, writing one keeps it
			cause_d = cause_q & wbyte[5:0];
		end
		cause_d[`WDT_CAUSE_USB]      = cause_d[`WDT_CAUSE_USB] |
			i_reset_event.usb;
		cause_d[`WDT_CAUSE_SCAN]     = cause_d[`WDT_CAUSE_SCAN] |
			i_reset_event.scan;
		cause_d[`WDT_CAUSE_TIMEOUT]  = cause_d[`WDT_CAUSE_TIMEOUT] |
			o_wdt_reset;
		cause_d[`WDT_CAUSE_BROWNOUT] = cause_d[`WDT_CAUSE_BROWNOUT] |
			i_reset_event.brownout;
		cause_d[`WDT_CAUSE_PIN]      = cause_d[`WDT_CAUSE_PIN] |
			i_reset_event.pin;
	end

	// Power-on sets its own flag and clears the others
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cause_q <= `WDT_CAUSE_RST_VAL;
		end else begin
			cause_q <= cause_d;
		end
	end

	// Fuse locks the enables; the timeout cause forces reset enable
	assign irq_en_eff   = ~i_always_on_fuse & irq_en_q;
	assign reset_en_eff = i_always_on_fuse | reset_en_q |
		cause_q[`WDT_CAUSE_TIMEOUT];

	// Mode decode from fuse and the two enables
	always_comb begin
		unique case ({i_always_on_fuse, reset_en_eff, irq_en_eff})
			3'b000:  mode = MODE_STOPPED;
			3'b001:  mode = MODE_IRQ;
			3'b011:  mode = MODE_IRQ_RESET;
			default: mode = MODE_RESET;
		endcase
	end

	assign o_mode = mode;

	// Control register read view
	assign ctrl_rd = {irq_flag_q, irq_en_eff, psel_q[3], unlock_q,
		reset_en_eff, psel_q[2:0]};

	// Change window: opened by one write with unlock and reset enable
	always_ff @(posedge i_clk) begin
		if (i_rst | sys_reset) begin
			unlock_q     <= 1'b0;
			unlock_cnt_q <= 2'd0;
		end else if (wr_ctrl & wbyte[`WDT_CTRL_UNLOCK] &
			wbyte[`WDT_CTRL_RESET_EN]) begin
			unlock_q     <= 1'b1;
			unlock_cnt_q <= 2'd0;
		end else if (wr_ctrl & unlock_q) begin
			unlock_q     <= 1'b0;
		end else if (unlock_q) begin
			// Closed by hardware four cycles after opening
			if (unlock_cnt_q == 2'(`WDT_UNLOCK_CYCLES - 1)) begin
				unlock_q <= 1'b0;
			end
			unlock_cnt_q <= unlock_cnt_q + 2'd1;
		end
	end

	// Reset enable: setting is free, clearing needs the open window
	always_ff @(posedge i_clk) begin
		if (i_rst | sys_reset) begin
			reset_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			if (wbyte[`WDT_CTRL_RESET_EN]) begin
				reset_en_q <= 1'b1;
			end else if (unlock_q) begin
				reset_en_q <= 1'b0;
			end
		end
	end

	// Period select changes only inside the open window
	always_ff @(posedge i_clk) begin
		if (i_rst | sys_reset) begin
			psel_q <= 4'h0;
		end else if (wr_ctrl & unlock_q) begin
			psel_q <= {wbyte[`WDT_CTRL_PSEL3],
				wbyte[`WDT_CTRL_PSEL2:`WDT_CTRL_PSEL0]};
		end
	end

	// Irq enable: software writes it, vector entry in combined mode clears it
	always_ff @(posedge i_clk) begin
		if (i_rst | sys_reset) begin
			irq_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			irq_en_q <= wbyte[`WDT_CTRL_IRQ_EN];
		end else if (i_vector_ack & (mode == MODE_IRQ_RESET)) begin
			irq_en_q <= 1'b0;
		end
	end

	// Irq flag: timeout sets it, vector entry or a written one clears it
	always_ff @(posedge i_clk) begin
		if (i_rst | sys_reset) begin
			irq_flag_q <= 1'b0;
		end else if (to_set_flag) begin
			irq_flag_q <= 1'b1;
		end else if (i_vector_ack |
			(wr_ctrl & wbyte[`WDT_CTRL_IRQ_FLAG])) begin
			irq_flag_q <= 1'b0;
		end
	end

	// Interrupt request needs both enables and the flag
	assign o_irq_req = irq_flag_q & irq_en_eff & i_global_irq_en;

	// Last count of the selected period; reserved codes use the longest
	always_comb begin
		if (psel_q > `WDT_PSEL_MAX) begin
			limit = CW'((BASE_CYCLES << `WDT_PSEL_MAX) - 1);
		end else begin
			limit = CW'((BASE_CYCLES << psel_q) - 1);
		end
	end

	assign timeout = tick & (mode != MODE_STOPPED) & (cnt_q >= limit);

	// Timeout action per mode; a second timeout in combined mode resets
	assign to_set_flag = timeout & ((mode == MODE_IRQ) |
		((mode == MODE_IRQ_RESET) & ~irq_flag_q));
	assign to_reset = timeout & ((mode == MODE_RESET) |
		((mode == MODE_IRQ_RESET) & irq_flag_q));

	// Oscillator cycle counter; control and restarts share the clock
	always_ff @(posedge i_clk) begin
		if (i_rst | sys_reset) begin
			cnt_q <= '0;
		end else if (i_restart | (mode == MODE_STOPPED)) begin
			cnt_q <= '0;
		end else if (timeout) begin
			cnt_q <= '0;
		end else if (tick) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	// Reset pulse lasts exactly one system clock cycle
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wdt_reset <= 1'b0;
		end else begin
			o_wdt_reset <= to_reset & ~i_restart;
		end
	end

endmodule
`default_nettype wire

/* File: tb/wdt_core_props.sv */
// Concurrent checks on the watchdog block ports
`timescale 1ns/1ps
`include "wdt_params.svh"
`default_nettype none
module wdt_core_props #(
	parameter int BASE_CYCLES = 4, // Shortest period
	parameter int OSC_DIV     = 2  // Clocks per osc cycle
) (
	input wire logic                     i_clk,
	input wire logic                     i_rst,
	input wire wdt_pkg::avs_req_type     i_avs,
	input wire logic [31:0]              o_avs_readdata,
	input wire logic                     o_avs_waitrequest,
	input wire wdt_pkg::reset_event_type i_reset_event,
	input wire logic                     i_always_on_fuse,
	input wire logic                     i_global_irq_en,
	input wire logic                     i_vector_ack,
	input wire logic                     i_restart,
	input wire logic                     o_irq_req,
	input wire logic                     o_wdt_reset,
	input wire wdt_pkg::wdt_mode_type    o_mode
);
	import wdt_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Read of the cause register completing
	sequence s_cause_rd;
		i_avs.read && !o_avs_waitrequest && i_avs.address == `WDT_OFS_CAUSE;
	endsequence
	// Flag standing with nothing to clear it
	sequence s_irq_quiet;
		o_irq_req && i_global_irq_en && !i_vector_ack && !i_avs.write
			&& i_reset_event == '0 && !o_wdt_reset;
	endsequence
	property p_rsv; s_cause_rd |-> o_avs_readdata[31:6] == 26'h0; endproperty
	a_rsv: assert property (p_rsv)
		else $error("cause reserved bits not zero");
	property p_hold;
		s_irq_quiet ##1 i_global_irq_en |-> o_irq_req;
	endproperty
	a_hold: assert property (p_hold)
		else $error("irq flag dropped by itself");
	property p_gie; o_irq_req |-> i_global_irq_en; endproperty
	a_gie: assert property (p_gie)
		else $error("irq request without global enable");
	property p_onehot; $onehot(o_mode); endproperty
	a_onehot: assert property (p_onehot)
		else $error("mode not one-hot");
	property p_rmode;
		$rose(o_wdt_reset) |-> $past(o_mode) inside {MODE_RESET, MODE_IRQ_RESET};
	endproperty
	a_rmode: assert property (p_rmode)
		else $error("reset pulse outside a reset mode");
	property p_vec; i_vector_ack |=> !o_irq_req; endproperty
	a_vec: assert property (p_vec)
		else $error("irq still requested after vector entry");
	property p_fuse; i_always_on_fuse |-> o_mode == MODE_RESET; endproperty
	a_fuse: assert property (p_fuse)
		else $error("fuse does not force reset mode");
	property p_restart; i_restart |=> !o_wdt_reset; endproperty
	a_restart: assert property (p_restart)
		else $error("reset pulse after restart");
	property p_pulse; o_wdt_reset |=> !o_wdt_reset; endproperty
	a_pulse: assert property (p_pulse)
		else $error("reset pulse longer than one cycle");
endmodule
bind wdt_core wdt_core_props #(.BASE_CYCLES(BASE_CYCLES), .OSC_DIV(OSC_DIV))
	u_props (.i_clk(i_clk), .i_rst(i_rst), .i_avs(i_avs),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_reset_event(i_reset_event), .i_always_on_fuse(i_always_on_fuse),
	.i_global_irq_en(i_global_irq_en), .i_vector_ack(i_vector_ack),
	.i_restart(i_restart), .o_irq_req(o_irq_req),
	.o_wdt_reset(o_wdt_reset), .o_mode(o_mode));
`default_nettype wire

/* File: tb/tb_watchdog_and_reset_cause.sv */
// Self-checking bench of the watchdog and reset-cause block
`timescale 1ns/1ps
`include "wdt_params.svh"
`default_nettype none
module tb_watchdog_and_reset_cause;
	import wdt_pkg::*;
	localparam int BASE = 4; // Shortened period
	localparam int DIV  = 2; // Shortened divider
	logic            i_clk, i_rst, fuse, gie, vack, rstrt, irq, wdt_rst, wq;
	avs_req_type     req;
	logic [31:0]     rdata;
	reset_event_type ev;
	wdt_mode_type    mode;
	int              errors = 0, tests_run = 0, cyc = 0, nres = 0;
	wdt_core #(.BASE_CYCLES(BASE), .OSC_DIV(DIV)) u_dut (.i_clk(i_clk),
		.i_rst(i_rst), .i_avs(req), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wq), .i_reset_event(ev), .i_always_on_fuse(fuse),
		.i_global_irq_en(gie), .i_vector_ack(vack), .i_restart(rstrt),
		.o_irq_req(irq), .o_wdt_reset(wdt_rst), .o_mode(mode));
	// Clock and cycle count
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (wdt_rst === 1'b1) nres <= nres + 1;
	end
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One bus cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] r);
		logic done;
		int n;
		n = 0;
		req <= '{address: a, read: !w, write: w, writedata: {24'h0, d},
			byteenable: 4'hf};
		// Request stands until waitrequest is sampled low at a rising edge
		do begin
			@(posedge i_clk);
			done = (wq === 1'b0);
			r = rdata[7:0];
			n++;
		end while (!done && n < 20);
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge i_clk);
		if (!done) check("bus", 16'h1, 16'h0);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] t;
		bus(1'b1, a, d, t);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, string nm);
		logic [7:0] t;
		bus(1'b0, a, 8'h0, t);
		check(nm, {8'h0, e}, {8'h0, t});
	endtask
	task automatic chk_mode(input wdt_mode_type e);
		@(negedge i_clk);
		check("mode", {12'h0, e}, {12'h0, mode});
		@(posedge i_clk);
	endtask
	task automatic kick;
		rstrt <= 1'b1;
		@(posedge i_clk);
		rstrt <= 1'b0;
	endtask
	task automatic por;
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
	endtask
	// Waits for the irq request or the reset pulse, returns the cycle
	task automatic wait_sig(input logic s, output int t);
		int n;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while ((s ? wdt_rst : irq) !== 1'b1 && n < 9000);
		t = cyc;
		@(posedge i_clk);
		if (n >= 9000) check("wait", 16'h1, 16'h0);
	endtask
	// Sticky cause flags, clear by zero, power-on value
	task automatic t_cause;
		logic [7:0] m;
		m = 8'h00;
		rd(`WDT_OFS_CAUSE, 8'h01, "cause_por");
		rd(`WDT_OFS_CTRL, 8'h00, "ctrl_por");
		rd(4'h8, 8'h00, "unmapped");
		wr(`WDT_OFS_CAUSE, 8'h3e);
		rd(`WDT_OFS_CAUSE, 8'h00, "cause_clr");
		for (int k = 0; k < 4; k++) begin
			ev <= reset_event_type'(4'h8 >> k);
			@(posedge i_clk);
			ev <= '0;
			// Usb and scan land in bits 5..4, brownout and pin in 2..1
			m = m | ((k < 2) ? (8'h20 >> k) : (8'h10 >> k));
			rd(`WDT_OFS_CAUSE, m, "cause_ev");
		end
		wr(`WDT_OFS_CAUSE, 8'h00);
		rd(`WDT_OFS_CAUSE, 8'h00, "cause_zero");
		ev <= '{usb: 1'b1, default: 1'b0};
		@(posedge i_clk);
		ev <= '0;
		por;
		rd(`WDT_OFS_CAUSE, 8'h01, "cause_por2");
		wr(`WDT_OFS_CAUSE, 8'h00);
	endtask
	// Periods of codes 0 to 10, flag clearing and the global enable
	task automatic t_period;
		int t0, t1;
		logic [7:0] ps;
		gie <= 1'b1;
		for (int c = 0; c <= 10; c++) begin
			ps = {2'b00, c[3], 2'b00, c[2:0]};
			kick;
			wr(`WDT_OFS_CTRL, 8'h18 | ps);
			wr(`WDT_OFS_CTRL, 8'hc0 | ps);
			if (c == 0) chk_mode(MODE_IRQ);
			wait_sig(1'b0, t0);
			wr(`WDT_OFS_CTRL, 8'hc0 | ps);
			wait_sig(1'b0, t1);
			check("period", 16'((BASE << ((c > 9) ? 9 : c)) * DIV),
				16'(t1 - t0));
		end
		gie <= 1'b0;
		@(posedge i_clk);
		check("irq_gie", 16'h0, {15'h0, irq});
		vack <= 1'b1;
		@(posedge i_clk);
		vack <= 1'b0;
		rd(`WDT_OFS_CTRL, 8'h62, "vec_irq");
	endtask
	// Protected changes and the four-cycle window
	task automatic t_protect;
		wr(`WDT_OFS_CTRL, 8'h40);
		rd(`WDT_OFS_CTRL, 8'h62, "no_unlock");
		kick;
		wr(`WDT_OFS_CTRL, 8'h3a);
		rd(`WDT_OFS_CTRL, 8'h3a, "unlock_set");
		repeat (2) @(posedge i_clk);
		wr(`WDT_OFS_CTRL, 8'h22);
		rd(`WDT_OFS_CTRL, 8'h2a, "win_closed");
		wr(`WDT_OFS_CTRL, 8'h3a);
		wr(`WDT_OFS_CTRL, 8'h22);
		rd(`WDT_OFS_CTRL, 8'h22, "win_open");
		chk_mode(MODE_STOPPED);
	endtask
	// Restarts hold off reset; time-out sets flag and forces enable
	task automatic t_reset;
		int t0, n0;
		// Shortest period, so a missed restart would fire quickly
		wr(`WDT_OFS_CTRL, 8'h18);
		wr(`WDT_OFS_CTRL, 8'h08);
		chk_mode(MODE_RESET);
		n0 = nres;
		repeat (10) begin
			kick;
			repeat (3) @(posedge i_clk);
		end
		check("restart", 16'(n0), 16'(nres));
		wait_sig(1'b1, t0);
		rd(`WDT_OFS_CAUSE, 8'h08, "cause_wdt");
		rd(`WDT_OFS_CTRL, 8'h08, "forced_en");
		wr(`WDT_OFS_CTRL, 8'h18);
		wr(`WDT_OFS_CTRL, 8'h00);
		rd(`WDT_OFS_CTRL, 8'h08, "still_en");
		kick;
		wr(`WDT_OFS_CAUSE, 8'h00);
		rd(`WDT_OFS_CTRL, 8'h00, "en_free");
	endtask
	// Interrupt first, then reset after vector entry
	task automatic t_comb;
		int t0;
		gie <= 1'b1;
		wr(`WDT_OFS_CTRL, 8'h48);
		chk_mode(MODE_IRQ_RESET);
		wait_sig(1'b0, t0);
		vack <= 1'b1;
		@(posedge i_clk);
		vack <= 1'b0;
		chk_mode(MODE_RESET);
		rd(`WDT_OFS_CTRL, 8'h08, "vec_comb");
		wait_sig(1'b1, t0);
		kick;
		wr(`WDT_OFS_CAUSE, 8'h00);
	endtask
	// Always-on fuse locks the enables
	task automatic t_fuse;
		fuse <= 1'b1;
		chk_mode(MODE_RESET);
		wr(`WDT_OFS_CTRL, 8'h18);
		wr(`WDT_OFS_CTRL, 8'h40);
		rd(`WDT_OFS_CTRL, 8'h08, "fuse_lock");
		fuse <= 1'b0;
		por;
	endtask
	// Watchdog on the run length
	initial begin
		repeat (60000) @(posedge i_clk);
		errors++;
		print_verdict;
	end
	initial begin
		{i_rst, fuse, gie, vack, rstrt} = 5'b10000;
		req = '0;
		ev = '0;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk_mode(MODE_STOPPED);
		t_cause;
		t_period;
		t_protect;
		t_reset;
		t_comb;
		t_fuse;
		print_verdict;
	end
endmodule
`default_nettype wire
